/* File: icc_defines.svh */
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ICC_OFS_CH2_SENSOR_SETUP  8'h24
`define ICC_OFS_CH0_FAST_TRACK    8'h25
`define ICC_OFS_CH3_SENSOR_SETUP  8'h26
`define ICC_OFS_CH1_2_FAST_TRACK  8'h28
`define ICC_OFS_CH3_FAST_TRACK    8'h2b

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ICC_RST_SENSOR_SETUP      8'h04
`define ICC_RST_CH0_FAST_TRACK    8'hda
`define ICC_RST_CH1_2_FAST_TRACK  8'h50
`define ICC_RST_CH3_FAST_TRACK    8'h01
`define ICC_RDATA_UNMAPPED        8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ICC_SETUP_RES_BIT         7
`define ICC_SETUP_FREQ_MSB        6
`define ICC_SETUP_FREQ_LSB        5
`define ICC_SETUP_CYC_MSB         4
`define ICC_SETUP_CYC_LSB         0
`define ICC_FT0_LSB               1
`define ICC_FT1_LSB               4
`define ICC_FT2_LSB               6
`define ICC_FT3_LSB               0

`endif

/* File: icc_pkg.sv */
package icc_pkg;

  typedef enum logic [1:0] {
    ICC_FREQ_1M_3M3   = 2'h0,
    ICC_FREQ_3M3_10M  = 2'h1,
    ICC_FREQ_10M_30M  = 2'h2,
    ICC_FREQ_RESERVED = 2'h3
  } icc_freq_range_t;

  typedef enum logic {
    ICC_RES_50_4K   = 1'h0,
    ICC_RES_800_10K = 1'h1
  } icc_res_range_t;

  typedef logic [1:0] icc_track_factor_t;

endpackage : icc_pkg

/* File: icc_sensor_setup.sv */
`timescale 1ns/100ps
`include "icc_defines.svh"

module icc_sensor_setup (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     wr_en_i,
  input  wire logic [7:0]               wdata_i,
  output logic      [7:0]               setup_o,
  output icc_pkg::icc_res_range_t       resistance_range_o,
  output icc_pkg::icc_freq_range_t      frequency_range_o,
  output logic      [4:0]               cycle_count_o,
  output logic                          freq_reserved_o
);

  logic [7:0] setup_r;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      setup_r <= `ICC_RST_SENSOR_SETUP;
    end else if (wr_en_i) begin
      setup_r <= wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // field split
  // ---------------------------------------------------------------
  assign setup_o            = setup_r;
  assign resistance_range_o = icc_pkg::icc_res_range_t'(setup_r[`ICC_SETUP_RES_BIT]);
  assign frequency_range_o  = icc_pkg::icc_freq_range_t'(
                                setup_r[`ICC_SETUP_FREQ_MSB:`ICC_SETUP_FREQ_LSB]);
  assign cycle_count_o      = setup_r[`ICC_SETUP_CYC_MSB:`ICC_SETUP_CYC_LSB];
  // code 3 is stored as written; the flag lets the sensor front end hold off
  assign freq_reserved_o    = (frequency_range_o == icc_pkg::ICC_FREQ_RESERVED);

endmodule : icc_sensor_setup

/* File: icc_config_regs.sv */
`timescale 1ns/100ps
`include "icc_defines.svh"

module icc_config_regs (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic [7:0]               reg_addr_i,
  input  wire logic                     reg_wr_i,
  input  wire logic [7:0]               reg_wdata_i,
  input  wire logic                     reg_rd_i,
  output logic      [7:0]               reg_rdata_o,
  output logic                          reg_rvalid_o,
  output icc_pkg::icc_res_range_t       ch2_resistance_range_o,
  output icc_pkg::icc_freq_range_t      ch2_frequency_range_o,
  output logic      [4:0]               ch2_cycle_count_o,
  output logic                          ch2_freq_reserved_o,
  output icc_pkg::icc_res_range_t       ch3_resistance_range_o,
  output icc_pkg::icc_freq_range_t      ch3_frequency_range_o,
  output logic      [4:0]               ch3_cycle_count_o,
  output logic                          ch3_freq_reserved_o,
  output icc_pkg::icc_track_factor_t    ch0_fast_track_factor_o,
  output icc_pkg::icc_track_factor_t    ch1_fast_track_factor_o,
  output icc_pkg::icc_track_factor_t    ch2_fast_track_factor_o,
  output icc_pkg::icc_track_factor_t    ch3_fast_track_factor_o
);

  logic [7:0] ch2_setup;
  logic [7:0] ch3_setup;
  logic [7:0] ch0_track_r;
  logic [7:0] ch1_2_track_r;
  logic [7:0] ch3_track_r;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       rvalid_r;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  function automatic icc_pkg::icc_track_factor_t factor_at(input logic [7:0] val,
                                                           input int       lsb);
    factor_at = icc_pkg::icc_track_factor_t'(val >> lsb);
  endfunction : factor_at

  // ---------------------------------------------------------------
  // sensor setup registers
  // ---------------------------------------------------------------
  // one module for both channels keeps layout and encodings identical
  icc_sensor_setup u_ch2_setup (
    .ref_clk_i          (ref_clk_i),
    .rstn_i             (rstn_i),
    .wr_en_i            (reg_wr_i && hit(reg_addr_i, `ICC_OFS_CH2_SENSOR_SETUP)),
    .wdata_i            (reg_wdata_i),
    .setup_o            (ch2_setup),
    .resistance_range_o (ch2_resistance_range_o),
    .frequency_range_o  (ch2_frequency_range_o),
    .cycle_count_o      (ch2_cycle_count_o),
    .freq_reserved_o    (ch2_freq_reserved_o)
  );

  icc_sensor_setup u_ch3_setup (
    .ref_clk_i          (ref_clk_i),
    .rstn_i             (rstn_i),
    .wr_en_i            (reg_wr_i && hit(reg_addr_i, `ICC_OFS_CH3_SENSOR_SETUP)),
    .wdata_i            (reg_wdata_i),
    .setup_o            (ch3_setup),
    .resistance_range_o (ch3_resistance_range_o),
    .frequency_range_o  (ch3_frequency_range_o),
    .cycle_count_o      (ch3_cycle_count_o),
    .freq_reserved_o    (ch3_freq_reserved_o)
  );

  // ---------------------------------------------------------------
  // fast tracking registers
  // ---------------------------------------------------------------
  // reserved bits are plain storage; the host is expected to preserve them
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ch0_track_r <= `ICC_RST_CH0_FAST_TRACK;
    end else if (reg_wr_i && hit(reg_addr_i, `ICC_OFS_CH0_FAST_TRACK)) begin
      ch0_track_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ch1_2_track_r <= `ICC_RST_CH1_2_FAST_TRACK;
    end else if (reg_wr_i && hit(reg_addr_i, `ICC_OFS_CH1_2_FAST_TRACK)) begin
      ch1_2_track_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ch3_track_r <= `ICC_RST_CH3_FAST_TRACK;
    end else if (reg_wr_i && hit(reg_addr_i, `ICC_OFS_CH3_FAST_TRACK)) begin
      ch3_track_r <= reg_wdata_i;
    end
  end

  assign ch0_fast_track_factor_o = factor_at(ch0_track_r, `ICC_FT0_LSB);
  assign ch1_fast_track_factor_o = factor_at(ch1_2_track_r, `ICC_FT1_LSB);
  assign ch2_fast_track_factor_o = factor_at(ch1_2_track_r, `ICC_FT2_LSB);
  assign ch3_fast_track_factor_o = factor_at(ch3_track_r, `ICC_FT3_LSB);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    case (reg_addr_i)
      `ICC_OFS_CH2_SENSOR_SETUP: rdata_nxt = ch2_setup;
      `ICC_OFS_CH0_FAST_TRACK:   rdata_nxt = ch0_track_r;
      `ICC_OFS_CH3_SENSOR_SETUP: rdata_nxt = ch3_setup;
      `ICC_OFS_CH1_2_FAST_TRACK: rdata_nxt = ch1_2_track_r;
      `ICC_OFS_CH3_FAST_TRACK:   rdata_nxt = ch3_track_r;
      default:                   rdata_nxt = `ICC_RDATA_UNMAPPED;
    endcase
  end

  // read data is held until the next read so the serial side can shift it out
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_r <= `ICC_RDATA_UNMAPPED;
    end else if (reg_rd_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_i;
    end
  end

  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;

endmodule : icc_config_regs

/* File: icc_config_regs_sva.sv */
`timescale 1ns/100ps
module icc_chk (
  input wire logic                       ref_clk_i,
  input wire logic                       rstn_i,
  input wire logic [7:0]                 reg_addr_i,
  input wire logic                       reg_wr_i,
  input wire logic [7:0]                 reg_wdata_i,
  input wire logic                       reg_rd_i,
  input wire logic [7:0]                 reg_rdata_o,
  input wire logic                       reg_rvalid_o,
  input wire icc_pkg::icc_res_range_t    ch2_resistance_range_o,
  input wire logic [4:0]                 ch2_cycle_count_o,
  input wire logic                       ch2_freq_reserved_o,
  input wire logic [4:0]                 ch3_cycle_count_o,
  input wire icc_pkg::icc_track_factor_t ch0_fast_track_factor_o,
  input wire icc_pkg::icc_track_factor_t ch2_fast_track_factor_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wr(logic [7:0] ad);
    reg_wr_i && reg_addr_i == ad;
  endsequence
  // valid must drop unless another read was taken
  sequence s_rd_ans;
    ##1 reg_rvalid_o ##1 (!reg_rvalid_o || $past(reg_rd_i));
  endsequence
  a_read_answer: assert property (reg_rd_i |-> s_rd_ans)
    else $error("read valid not a single cycle");
  a_res2_write: assert property (s_wr(8'h24) |=> ch2_resistance_range_o == $past(reg_wdata_i[7]))
    else $error("ch2 range wrong");
  a_resv2_flag: assert property (s_wr(8'h24) |=> ch2_freq_reserved_o == ($past(reg_wdata_i[6:5]) == 2'h3))
    else $error("reserved flag wrong");
  a_cyc2_write: assert property (s_wr(8'h24) |=> ch2_cycle_count_o == $past(reg_wdata_i[4:0]))
    else $error("ch2 cycles wrong");
  a_cyc3_write: assert property (s_wr(8'h26) |=> ch3_cycle_count_o == $past(reg_wdata_i[4:0]))
    else $error("ch3 cycles wrong");
  a_ft0_write: assert property (s_wr(8'h25) |=> ch0_fast_track_factor_o == $past(reg_wdata_i[2:1]))
    else $error("ch0 factor wrong");
  a_ft2_write: assert property (s_wr(8'h28) |=> ch2_fast_track_factor_o == $past(reg_wdata_i[7:6]))
    else $error("ch2 factor wrong");
  a_ft3_readback: assert property (s_wr(8'h2b) ##1 !reg_wr_i ##1 (s_wr(8'h2b) or (reg_rd_i && reg_addr_i == 8'h2b && !reg_wr_i)) |=> !reg_rvalid_o || reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("ch3 track readback wrong");
endmodule : icc_chk

/* File: icc_host_model.sv */
`timescale 1ns/100ps
module icc_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o,
  output logic            timeout_o
);
  initial begin
    {reg_addr_o, reg_wr_o, reg_wdata_o, reg_rd_o, timeout_o} = '0;
  end
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk_i) #1;
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {ad, d, 1'b1};
    @(posedge ref_clk_i) #1;
    // idle lines flip so a stale value never looks like a request
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {~ad, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    int i;
    @(posedge ref_clk_i) #1;
    {reg_addr_o, reg_rd_o} = {ad, 1'b1};
    @(posedge ref_clk_i) #1;
    {reg_addr_o, reg_rd_o} = {~ad, 1'b0};
    for (i = 0; i < 4 && reg_rvalid_i !== 1'b1; i++) @(posedge ref_clk_i) #1;
    timeout_o = (reg_rvalid_i !== 1'b1);
    d = reg_rdata_i;
  endtask : rd
  task automatic rmw(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] d;
    rd(ad, d);
    wr(ad, (d & ~m) | v);
  endtask : rmw
endmodule : icc_host_model

/* File: test_icc_config_regs.sv */
`timescale 1ns/100ps
bind icc_config_regs icc_chk u_icc_chk (
  .ref_clk_i               (ref_clk_i),
  .rstn_i                  (rstn_i),
  .reg_addr_i              (reg_addr_i),
  .reg_wr_i                (reg_wr_i),
  .reg_wdata_i             (reg_wdata_i),
  .reg_rd_i                (reg_rd_i),
  .reg_rdata_o             (reg_rdata_o),
  .reg_rvalid_o            (reg_rvalid_o),
  .ch2_resistance_range_o  (ch2_resistance_range_o),
  .ch2_cycle_count_o       (ch2_cycle_count_o),
  .ch2_freq_reserved_o     (ch2_freq_reserved_o),
  .ch3_cycle_count_o       (ch3_cycle_count_o),
  .ch0_fast_track_factor_o (ch0_fast_track_factor_o),
  .ch2_fast_track_factor_o (ch2_fast_track_factor_o)
);
module test_icc_config_regs;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, wr, rd, rv, to, q2, q3;
  logic [7:0] a, wd, rdat, v, g;
  logic [4:0] c2, c3;
  icc_pkg::icc_res_range_t r2, r3;
  icc_pkg::icc_freq_range_t f2, f3;
  icc_pkg::icc_track_factor_t t0, t1, t2, t3;
  int errors = 0, check_count = 0, k;
  logic [7:0] ofs [5] = '{8'h24, 8'h25, 8'h26, 8'h28, 8'h2b};
  logic [7:0] rst [5] = '{8'h04, 8'hda, 8'h04, 8'h50, 8'h01};
  always #25 ref_clk_i = ~ref_clk_i;
  icc_host_model u_icc_host_model (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdat),
    .reg_rvalid_i(rv), .reg_addr_o(a), .reg_wr_o(wr), .reg_wdata_o(wd),
    .reg_rd_o(rd), .timeout_o(to));
  icc_config_regs u_icc_config_regs (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(a), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .ch2_resistance_range_o(r2), .ch2_frequency_range_o(f2),
    .ch2_cycle_count_o(c2), .ch2_freq_reserved_o(q2), .ch3_resistance_range_o(r3),
    .ch3_frequency_range_o(f3), .ch3_cycle_count_o(c3), .ch3_freq_reserved_o(q3),
    .ch0_fast_track_factor_o(t0), .ch1_fast_track_factor_o(t1),
    .ch2_fast_track_factor_o(t2), .ch3_fast_track_factor_o(t3));
  task automatic finish_test;
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
    u_icc_host_model.rd(ad, g);
    chk("rdata", e, g);
  endtask : rdc
  always @(posedge to) begin
    errors++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    foreach (ofs[i]) rdc(ofs[i], rst[i]);
    chk("fields", 8'h55, {t0, t1, t2, t3});
    chk("set2", 8'h04, {r2, f2, c2});
    for (k = 0; k < 4; k++) begin
      v = {k[0], k[1:0], 5'h1f - k[4:0]};
      u_icc_host_model.wr(8'h24, v);
      chk("set2", v, {r2, f2, c2});
      chk("resv2", {7'h0, k == 3}, {7'h0, q2});
      rdc(8'h24, v);
    end
    u_icc_host_model.wr(8'h26, 8'hfb);
    chk("set3", 8'hfb, {r3, f3, c3});
    chk("resv3", 8'h01, {7'h0, q3});
    u_icc_host_model.wr(8'h27, 8'hff);
    rdc(8'h27, 8'h00);
    rdc(8'h26, 8'hfb);
    u_icc_host_model.wr(8'h28, 8'h90);
    chk("ft21", 8'h09, {4'h0, t2, t1});
    u_icc_host_model.rmw(8'h25, 8'h06, 8'h06);
    rdc(8'h25, 8'hde);
    chk("ft0", 8'h03, {6'h0, t0});
    u_icc_host_model.rmw(8'h2b, 8'h03, 8'h02);
    rdc(8'h2b, 8'h02);
    @(posedge ref_clk_i) #1 rstn_i = 1'b0;
    @(posedge ref_clk_i) #1 rstn_i = 1'b1;
    rdc(8'h28, 8'h50);
    chk("set2", 8'h04, {r2, f2, c2});
    chk("ft3", 8'h01, {6'h0, t3});
    finish_test;
  end
endmodule : test_icc_config_regs
